// >>> rtl/low_power_mode_control.sv
module low_power_mode_control #(
  parameter int STAB_CYCLES = lpm_pkg::OSC_STAB_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Reset sources and watchdog status
  input wire logic ext_reset,
  input wire logic wdg_reset,
  input wire logic wdg_active,
  // Data space write port
  input wire logic [7:0] data_addr,
  input wire logic [7:0] data_wdata,
  input wire logic data_we,
  // Core sequencer
  input wire logic instr_end,
  input wire logic idle_instr,
  input wire logic halt_instr,
  input wire logic return_from_interrupt,
  input wire logic aux_osc_req,
  input wire logic aux_osc_req_val,
  // Interrupt requests, already gated by per-source masks
  input wire logic nmi_req,
  input wire logic [2:0] irq_req,
  // Core control
  output logic core_reset,
  output logic fetch_en,
  output logic core_clk_en,
  output logic periph_clk_en,
  output logic osc_en,
  output logic low_freq_aux_osc,
  output logic resume,
  // Interrupt entry and exit
  output logic irq_take,
  output logic [2:0] irq_vec,
  output logic stack_push,
  output logic stack_pop,
  output logic [1:0] flag_set,
  // Option register fields
  output logic global_irq_enable,
  output logic port_a_level,
  output logic port_b_rising,
  // Status
  output logic [1:0] power_mode
);

  // Power state
  lpm_pkg::pwr_state_t state_r;
  lpm_pkg::pwr_state_t state_nxt;
  // Context and the one context saved underneath the nmi routine
  lpm_pkg::ctx_t ctx_r;
  lpm_pkg::ctx_t ctx_nxt;
  lpm_pkg::ctx_t nmi_saved_r;
  lpm_pkg::ctx_t nmi_saved_nxt;
  // Option register
  logic [7:0] interrupt_option_reg_r;
  logic [7:0] interrupt_option_reg_nxt;
  // Registered outputs
  logic core_reset_r;
  logic core_reset_nxt;
  logic fetch_en_r;
  logic fetch_en_nxt;
  logic core_clk_en_r;
  logic core_clk_en_nxt;
  logic periph_clk_en_r;
  logic periph_clk_en_nxt;
  logic osc_en_r;
  logic osc_en_nxt;
  logic aux_osc_r;
  logic aux_osc_nxt;
  logic resume_r;
  logic resume_nxt;
  logic irq_take_r;
  logic irq_take_nxt;
  logic [2:0] irq_vec_r;
  logic [2:0] irq_vec_nxt;
  logic stack_push_r;
  logic stack_push_nxt;
  logic stack_pop_r;
  logic stack_pop_nxt;

  // Combinational helpers
  logic any_reset;
  logic gen;
  logic nmi_ok;
  logic irq_ok;
  logic pending;
  logic idle_wake;
  logic halt_wake;
  logic stab_start;
  logic stab_done;
  logic lp_entry;
  logic to_halt;

  // Highest priority normal vector; port A wins, timer loses
  function automatic logic [2:0] pick_vec(input logic [2:0] req);
    logic [2:0] v;
    v = lpm_pkg::VEC_TIMER;
    if (req[0]) begin
      v = lpm_pkg::VEC_PORT_A;
    end else if (req[1]) begin
      v = lpm_pkg::VEC_PORT_B;
    end
    return v;
  endfunction

  stab_timer #(
    .CYCLES(STAB_CYCLES)
  ) u_stab (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(stab_start),
    .abort(any_reset),
    .done(stab_done)
  );

  assign core_reset = core_reset_r;
  assign fetch_en = fetch_en_r;
  assign core_clk_en = core_clk_en_r;
  assign periph_clk_en = periph_clk_en_r;
  assign osc_en = osc_en_r;
  assign low_freq_aux_osc = aux_osc_r;
  assign resume = resume_r;
  assign irq_take = irq_take_r;
  assign irq_vec = irq_vec_r;
  assign stack_push = stack_push_r;
  assign stack_pop = stack_pop_r;
  assign flag_set = ctx_r;
  assign global_irq_enable = interrupt_option_reg_r[lpm_pkg::GLOBAL_EN_BIT];
  assign port_a_level = interrupt_option_reg_r[lpm_pkg::LEVEL_SEL_BIT];
  assign port_b_rising = interrupt_option_reg_r[lpm_pkg::EDGE_SEL_BIT];
  assign power_mode = state_r;

  // Request qualification shared by entry, wake and arbitration
  always_comb begin
    any_reset = ext_reset | wdg_reset;
    gen = interrupt_option_reg_r[lpm_pkg::GLOBAL_EN_BIT];
    // The non-maskable source ignores the global enable for servicing
    nmi_ok = nmi_req && (ctx_r != lpm_pkg::CTX_NMI);
    irq_ok = gen && (|irq_req) && (ctx_r == lpm_pkg::CTX_MAIN);
    pending = nmi_ok || (gen && (|irq_req));
    // Without the global enable nothing wakes, not even the nmi line
    idle_wake = gen && (nmi_req || (|irq_req));
    halt_wake = gen && (nmi_req || (|(irq_req & lpm_pkg::HALT_WAKE_MASK)));
    lp_entry = instr_end && (idle_instr || halt_instr) && !pending;
    // A running watchdog would be starved by a stopped oscillator
    to_halt = halt_instr && !wdg_active;
    stab_start = (state_r == lpm_pkg::PM_HALT) && halt_wake;
  end

  // Option register and context tracking
  always_comb begin
    interrupt_option_reg_nxt = interrupt_option_reg_r;
    ctx_nxt = ctx_r;
    nmi_saved_nxt = nmi_saved_r;
    irq_take_nxt = 1'b0;
    irq_vec_nxt = irq_vec_r;
    stack_push_nxt = 1'b0;
    stack_pop_nxt = 1'b0;
    aux_osc_nxt = aux_osc_r;
    if (data_we && (data_addr == lpm_pkg::INT_OPT_ADDR)) begin
      interrupt_option_reg_nxt = data_wdata;
    end
    // Only the core and a reset change the oscillator choice; wake-ups leave it alone
    if (aux_osc_req && (state_r == lpm_pkg::PM_RUN)) begin
      aux_osc_nxt = aux_osc_req_val;
    end
    if ((state_r == lpm_pkg::PM_RUN) && fetch_en_r && instr_end && !lp_entry) begin
      if (return_from_interrupt && (ctx_r != lpm_pkg::CTX_MAIN)) begin
        stack_pop_nxt = 1'b1;
        if (ctx_r == lpm_pkg::CTX_NMI) begin
          ctx_nxt = nmi_saved_r;
        end else begin
          ctx_nxt = lpm_pkg::CTX_MAIN;
        end
      end else if (nmi_ok) begin
        // Nmi preempts main or a normal routine and remembers which
        irq_take_nxt = 1'b1;
        irq_vec_nxt = lpm_pkg::VEC_NMI;
        stack_push_nxt = 1'b1;
        nmi_saved_nxt = ctx_r;
        ctx_nxt = lpm_pkg::CTX_NMI;
      end else if (irq_ok) begin
        irq_take_nxt = 1'b1;
        irq_vec_nxt = pick_vec(irq_req);
        stack_push_nxt = 1'b1;
        ctx_nxt = lpm_pkg::CTX_IRQ;
      end
    end
  end

  // Power state machine and clock gating
  always_comb begin
    state_nxt = state_r;
    fetch_en_nxt = fetch_en_r;
    core_clk_en_nxt = core_clk_en_r;
    periph_clk_en_nxt = periph_clk_en_r;
    osc_en_nxt = osc_en_r;
    resume_nxt = 1'b0;
    core_reset_nxt = 1'b0;
    unique case (state_r)
      lpm_pkg::PM_RUN: begin
        if (lp_entry && fetch_en_r) begin
          fetch_en_nxt = 1'b0;
          core_clk_en_nxt = 1'b0;
          if (to_halt) begin
            state_nxt = lpm_pkg::PM_HALT;
            periph_clk_en_nxt = 1'b0;
            osc_en_nxt = 1'b0;
          end else begin
            state_nxt = lpm_pkg::PM_IDLE;
            periph_clk_en_nxt = 1'b1;
            osc_en_nxt = 1'b1;
          end
        end
      end
      lpm_pkg::PM_IDLE: begin
        // Oscillator never stopped, so no settling wait
        if (idle_wake) begin
          state_nxt = lpm_pkg::PM_RUN;
          fetch_en_nxt = 1'b1;
          core_clk_en_nxt = 1'b1;
          resume_nxt = 1'b1;
        end
      end
      lpm_pkg::PM_HALT: begin
        if (stab_start) begin
          state_nxt = lpm_pkg::PM_STAB;
          osc_en_nxt = 1'b1;
        end
      end
      lpm_pkg::PM_STAB: begin
        // Clocks are released only once the restarted oscillator is steady
        if (stab_done) begin
          state_nxt = lpm_pkg::PM_RUN;
          fetch_en_nxt = 1'b1;
          core_clk_en_nxt = 1'b1;
          periph_clk_en_nxt = 1'b1;
          resume_nxt = 1'b1;
        end
      end
    endcase
    // Reset from any source returns to run through the normal procedure
    if (any_reset) begin
      state_nxt = lpm_pkg::PM_RUN;
      fetch_en_nxt = 1'b0;
      core_clk_en_nxt = 1'b1;
      periph_clk_en_nxt = 1'b1;
      osc_en_nxt = 1'b1;
      core_reset_nxt = 1'b1;
    end else if (core_reset_r) begin
      fetch_en_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= lpm_pkg::PM_RUN;
      ctx_r <= lpm_pkg::CTX_MAIN;
      nmi_saved_r <= lpm_pkg::CTX_MAIN;
      interrupt_option_reg_r <= lpm_pkg::INT_OPT_RESET;
      core_reset_r <= 1'b1;
      fetch_en_r <= 1'b0;
      core_clk_en_r <= 1'b1;
      periph_clk_en_r <= 1'b1;
      osc_en_r <= 1'b1;
      aux_osc_r <= 1'b0;
      resume_r <= 1'b0;
      irq_take_r <= 1'b0;
      irq_vec_r <= lpm_pkg::VEC_NMI;
      stack_push_r <= 1'b0;
      stack_pop_r <= 1'b0;
    end else if (any_reset) begin
      state_r <= state_nxt;
      ctx_r <= lpm_pkg::CTX_MAIN;
      nmi_saved_r <= lpm_pkg::CTX_MAIN;
      interrupt_option_reg_r <= lpm_pkg::INT_OPT_RESET;
      core_reset_r <= core_reset_nxt;
      fetch_en_r <= fetch_en_nxt;
      core_clk_en_r <= core_clk_en_nxt;
      periph_clk_en_r <= periph_clk_en_nxt;
      osc_en_r <= osc_en_nxt;
      aux_osc_r <= 1'b0;
      resume_r <= 1'b0;
      irq_take_r <= 1'b0;
      irq_vec_r <= lpm_pkg::VEC_NMI;
      stack_push_r <= 1'b0;
      stack_pop_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ctx_r <= ctx_nxt;
      nmi_saved_r <= nmi_saved_nxt;
      interrupt_option_reg_r <= interrupt_option_reg_nxt;
      core_reset_r <= core_reset_nxt;
      fetch_en_r <= fetch_en_nxt;
      core_clk_en_r <= core_clk_en_nxt;
      periph_clk_en_r <= periph_clk_en_nxt;
      osc_en_r <= osc_en_nxt;
      aux_osc_r <= aux_osc_nxt;
      resume_r <= resume_nxt;
      irq_take_r <= irq_take_nxt;
      irq_vec_r <= irq_vec_nxt;
      stack_push_r <= stack_push_nxt;
      stack_pop_r <= stack_pop_nxt;
    end
  end

endmodule

// >>> rtl/lpm_pkg.sv
// Contract
// - Idle instruction stops fetch and execute; RAM, registers and peripherals keep going.
// - In idle the selected oscillator keeps running and clocking the peripherals.
// - Interrupt exit from idle resumes with no stabilisation delay.
// - External or watchdog reset during idle runs the ordinary reset procedure.
// - Halt acts as idle while the watchdog is active.
// - Halt stops the oscillator and waits for external interrupt or reset only.
// - Interrupt exit from halt waits for oscillator stabilisation before executing.
// - External reset during halt runs the ordinary reset procedure.
// - Wake-up by interrupt leaves the oscillator selection unchanged.
// - From main context the waking interrupt is serviced, then execution continues.
// - From non-maskable context any interrupt wakes; context stays non-maskable.
// - From interrupt context a normal wake continues the routine in interrupt context.
// - From interrupt context a non-maskable wake runs its routine first.
// - With global enable cleared no interrupt wakes the device; only reset does.
// - Low-power instruction is ignored while an enabled request is pending.
// - Return from interrupt restores previous flag set and pops the stack.
// - Global enable masks every source except the non-maskable one.
// - Global enable set enables all; option register write-only, cleared on reset.
package lpm_pkg;

  // Data space address of the interrupt option register
  localparam logic [7:0] INT_OPT_ADDR = 8'hC8;
  localparam logic [7:0] INT_OPT_RESET = 8'h00;
  // Field positions inside the interrupt option register
  localparam int LEVEL_SEL_BIT = 6;
  localparam int EDGE_SEL_BIT = 5;
  localparam int GLOBAL_EN_BIT = 4;

  // Oscillator restart settling time after halt
  localparam int OSC_STAB_NS = 16000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int OSC_STAB_CYCLES = (OSC_STAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Interrupt vector numbers
  localparam logic [2:0] VEC_NMI = 3'h0;
  localparam logic [2:0] VEC_PORT_A = 3'h1;
  localparam logic [2:0] VEC_PORT_B = 3'h2;
  localparam logic [2:0] VEC_TIMER = 3'h3;
  // Normal request bits that may wake from halt (external pins only)
  localparam logic [2:0] HALT_WAKE_MASK = 3'h3;

  typedef enum logic [1:0] {
    PM_RUN = 2'b00,
    PM_IDLE = 2'b01,
    PM_HALT = 2'b10,
    PM_STAB = 2'b11
  } pwr_state_t;

  typedef enum logic [1:0] {
    CTX_MAIN = 2'b00,
    CTX_IRQ = 2'b01,
    CTX_NMI = 2'b10
  } ctx_t;

endpackage

// >>> rtl/stab_timer.sv
module stab_timer #(
  parameter int CYCLES = lpm_pkg::OSC_STAB_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Control
  input wire logic start,
  input wire logic abort,
  output logic done
);

  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic busy_r;
  logic busy_nxt;
  logic done_r;
  logic done_nxt;

  assign done = done_r;

  always_comb begin
    cnt_nxt = cnt_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    if (abort) begin
      busy_nxt = 1'b0;
      cnt_nxt = '0;
    end else if (start) begin
      busy_nxt = 1'b1;
      cnt_nxt = CW'(CYCLES - 1);
    end else if (busy_r) begin
      if (cnt_r == '0) begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r - 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_r <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
    end
  end

endmodule

// >>> test/lpm_chk.sv
module lpm_chk #(
  parameter int STAB_CYCLES = lpm_pkg::OSC_STAB_CYCLES
) (
  // Clock and resets
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ext_reset,
  input wire logic wdg_reset,
  input wire logic wdg_active,
  // Requests
  input wire logic [7:0] data_addr,
  input wire logic [7:0] data_wdata,
  input wire logic data_we,
  input wire logic instr_end,
  input wire logic idle_instr,
  input wire logic halt_instr,
  input wire logic nmi_req,
  input wire logic [2:0] irq_req,
  // Responses
  input wire logic core_reset,
  input wire logic fetch_en,
  input wire logic periph_clk_en,
  input wire logic osc_en,
  input wire logic resume,
  input wire logic global_irq_enable,
  input wire logic [1:0] power_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] stab_cnt_r;
  logic [15:0] stab_cnt_nxt;
  // Settling can last thousands of cycles, too long for a repetition
  always_comb begin
    stab_cnt_nxt = (power_mode == 2'h3) ? stab_cnt_r + 16'h1 : 16'h0;
  end
  always_ff @(posedge sys_clk) begin
    stab_cnt_r <= rst ? 16'h0 : stab_cnt_nxt;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst || ext_reset || wdg_reset);
  property p_idle;
    power_mode == 2'h1 |-> osc_en && periph_clk_en && !fetch_en;
  endproperty
  a_idle: assert property (p_idle) else $error("idle clocks");
  property p_halt;
    power_mode == 2'h2 |-> !osc_en && !periph_clk_en && !fetch_en;
  endproperty
  a_halt: assert property (p_halt) else $error("halt clocks");
  property p_wdg;
    power_mode == 2'h0 && wdg_active |=> power_mode != 2'h2;
  endproperty
  a_wdg: assert property (p_wdg) else $error("halt with watchdog");
  property p_wake;
    power_mode == 2'h1 && global_irq_enable && (nmi_req || |irq_req)
      |=> power_mode == 2'h0 && fetch_en && resume;
  endproperty
  a_wake: assert property (p_wake) else $error("idle wake");
  property p_sleep;
    (power_mode == 2'h1 || power_mode == 2'h2) && !global_irq_enable |=> $stable(power_mode);
  endproperty
  a_sleep: assert property (p_sleep) else $error("woke while masked");
  property p_stab;
    power_mode == 2'h3 ##1 power_mode != 2'h3
      |-> stab_cnt_r >= STAB_CYCLES && stab_cnt_r <= STAB_CYCLES + 2;
  endproperty
  a_stab: assert property (p_stab) else $error("settling length");
  property p_refuse;
    power_mode == 2'h0 && instr_end && (idle_instr || halt_instr) && global_irq_enable
      && |irq_req |=> power_mode == 2'h0;
  endproperty
  a_refuse: assert property (p_refuse) else $error("slept while pending");
  property p_rst;
    disable iff (rst) ext_reset || wdg_reset |=> core_reset && power_mode == 2'h0 && !fetch_en;
  endproperty
  a_rst: assert property (p_rst) else $error("reset exit");
  property p_gen;
    data_we && data_addr == lpm_pkg::INT_OPT_ADDR
      |=> global_irq_enable == $past(data_wdata[lpm_pkg::GLOBAL_EN_BIT]);
  endproperty
  a_gen: assert property (p_gen) else $error("enable bit");
endmodule

// >>> test/core_model.sv
module core_model (
  // Clock
  input wire logic sys_clk,
  // Block side
  input wire logic core_reset,
  input wire logic fetch_en,
  input wire logic irq_take,
  input wire logic [2:0] irq_vec,
  output logic instr_end,
  output logic idle_instr,
  output logic halt_instr,
  output logic return_from_interrupt,
  output logic nmi_req,
  // Bench side
  input wire logic nmi_pin,
  input wire logic [1:0] op
);
  timeunit 1ns;
  timeprecision 1ps;
  // Cleared by the core reset pulse that stands while rst is held
  logic nmi_r;
  logic nmi_nxt;
  // One instruction ends every cycle the core runs
  assign instr_end = fetch_en;
  assign idle_instr = op == 2'h1;
  assign halt_instr = op == 2'h2;
  assign return_from_interrupt = op == 2'h3;
  assign nmi_req = nmi_r;
  // Outside core reset, the latch is cleared only when the core enters the non-maskable routine
  always_comb begin
    nmi_nxt = (nmi_r || nmi_pin) && !(irq_take && irq_vec == lpm_pkg::VEC_NMI);
  end
  always_ff @(negedge sys_clk) begin
    nmi_r <= core_reset ? 1'b0 : nmi_nxt;
  end
endmodule

// >>> test/low_power_mode_control_tb.sv
module low_power_mode_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STAB = 4;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic ext_reset = 1'b0;
  logic wdg_reset = 1'b0;
  logic wdg_active = 1'b0;
  logic [7:0] data_addr = 8'h00;
  logic [7:0] data_wdata = 8'h00;
  logic data_we = 1'b0;
  logic aux_osc_req = 1'b0;
  logic aux_osc_req_val = 1'b0;
  logic [2:0] irq_req = 3'h0;
  logic nmi_pin = 1'b0;
  logic [1:0] op = 2'h0;
  logic instr_end, idle_instr, halt_instr, return_from_interrupt, nmi_req;
  logic core_reset, fetch_en, core_clk_en, periph_clk_en, osc_en, low_freq_aux_osc;
  logic resume, irq_take, stack_push, stack_pop, global_irq_enable, port_a_level;
  logic port_b_rising;
  logic [2:0] irq_vec;
  logic [1:0] flag_set, power_mode;
  int miscompares = 0;
  int checks_done = 0;
  int tn = 0;
  int k;
  always #4 sys_clk = ~sys_clk;
  low_power_mode_control #(.STAB_CYCLES(STAB)) uut (.*);
  core_model core (.*);
  task automatic tick;
    @(negedge sys_clk);
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick;
    data_addr = a;
    data_wdata = d;
    data_we = 1'b1;
    tick;
    data_we = 1'b0;
  endtask
  task automatic ex(input logic [1:0] o);
    tick;
    op = o;
    tick;
    op = 2'h0;
  endtask
  task automatic endt;
    tn++;
    $display("test %0d done", tn);
  endtask
  // Sleep, wake by port A, expect no new entry, then return
  task automatic wake_ctx;
    ex(2'h1);
    irq_req = 3'h1;
    tick;
    chk(power_mode, 2'h0);
    tick;
    chk(irq_take, 1'b0);
    irq_req = 3'h0;
    ex(2'h3);
    chk({stack_pop, flag_set}, 3'b100);
  endtask
  task automatic close_out;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (8) tick;
    rst = 1'b0;
    tick;
    wr(lpm_pkg::INT_OPT_ADDR, 8'h70);
    chk({global_irq_enable, port_a_level, port_b_rising}, 3'b111);
    wr(8'hC9, 8'h00);
    chk(global_irq_enable, 1'b1);
    wr(lpm_pkg::INT_OPT_ADDR, 8'h10);
    chk({global_irq_enable, port_a_level, port_b_rising}, 3'b100);
    endt;
    aux_osc_req = 1'b1;
    aux_osc_req_val = 1'b1;
    tick;
    aux_osc_req = 1'b0;
    ex(2'h1);
    chk({power_mode, fetch_en, osc_en, periph_clk_en, core_clk_en}, 6'b010110);
    irq_req = 3'h4;
    tick;
    chk({power_mode, fetch_en, resume, low_freq_aux_osc, core_clk_en}, 6'b001111);
    tick;
    chk({irq_take, stack_push, irq_vec, flag_set}, 7'b1101101);
    irq_req = 3'h0;
    ex(2'h3);
    chk({stack_pop, flag_set}, 3'b100);
    endt;
    irq_req = 3'h1;
    ex(2'h1);
    chk({power_mode, flag_set}, 4'b0001);
    irq_req = 3'h0;
    wake_ctx;
    endt;
    ex(2'h2);
    chk({power_mode, osc_en, periph_clk_en, fetch_en}, 5'b10000);
    irq_req = 3'h4;
    tick;
    chk(power_mode, 2'h2);
    irq_req = 3'h2;
    tick;
    chk({power_mode, osc_en, fetch_en}, 4'b1110);
    k = 0;
    while (fetch_en !== 1'b1 && k < 50) begin
      tick;
      k++;
    end
    chk(k >= STAB && k <= STAB + 2, 1'b1);
    tick;
    chk({irq_take, irq_vec}, 4'b1010);
    irq_req = 3'h0;
    ex(2'h3);
    endt;
    wdg_active = 1'b1;
    ex(2'h2);
    chk(power_mode, 2'h1);
    nmi_pin <= 1'b1;
    tick;
    nmi_pin <= 1'b0;
    tick;
    chk({power_mode, resume}, 3'b001);
    tick;
    chk({irq_take, irq_vec, flag_set}, 6'b100010);
    wake_ctx;
    endt;
    // Sleep inside a normal routine, wake by nmi, unwind both levels
    irq_req = 3'h2;
    tick;
    irq_req = 3'h0;
    ex(2'h1);
    chk({power_mode, flag_set}, 4'b0101);
    nmi_pin <= 1'b1;
    tick;
    nmi_pin <= 1'b0;
    tick;
    tick;
    chk({irq_take, irq_vec, flag_set}, 6'b100010);
    ex(2'h3);
    chk({stack_pop, flag_set}, 3'b101);
    ex(2'h3);
    chk({stack_pop, flag_set}, 3'b100);
    endt;
    wr(lpm_pkg::INT_OPT_ADDR, 8'h00);
    ex(2'h1);
    nmi_pin <= 1'b1;
    tick;
    nmi_pin <= 1'b0;
    repeat (3) tick;
    chk(power_mode, 2'h1);
    wdg_reset = 1'b1;
    tick;
    chk({core_reset, power_mode, fetch_en}, 4'b1000);
    wdg_reset = 1'b0;
    tick;
    chk({core_reset, fetch_en}, 2'b01);
    endt;
    // External reset out of halt
    wdg_active = 1'b0;
    ex(2'h2);
    chk(power_mode, 2'h2);
    ext_reset = 1'b1;
    tick;
    chk({core_reset, power_mode, fetch_en, osc_en}, 5'b10001);
    ext_reset = 1'b0;
    tick;
    chk({core_reset, fetch_en, global_irq_enable}, 3'b010);
    endt;
    close_out;
  end
  // The tests need about 80 cycles
  initial begin
    repeat (2000) @(posedge sys_clk);
    miscompares++;
    close_out;
  end
endmodule
bind low_power_mode_control lpm_chk #(.STAB_CYCLES(STAB_CYCLES)) chk_i (.*);
